// [hdl/fmc_core.sv]
// Four-bit controller core: fetch, decode and execute with RAM, stack and ports.
// Assumes a synchronous program ROM answering rom_data within three mclk of rom_addr,
// pins asynchronous to mclk, and a classic Wishbone master for run control.
`timescale 1ns/100ps
`default_nettype none
`include "fmc_map.svh"

module fmc_core #(
  parameter int TMR_BITS  = `FMC_TMR_BITS,
  parameter bit CKO_IS_GP = 1'b0
) (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire fmc_pkg::fmc_wb_req_t wb_req,
  output logic                     wb_ack_o,
  output logic [31:0]              wb_dat_o,
  output logic [9:0]               rom_addr,
  input  wire logic [7:0]          rom_data,
  input  wire fmc_pkg::fmc_pins_t  pins,
  output logic [7:0]               l_out,
  output logic [3:0]               g_out,
  output logic [3:0]               d_out,
  output logic [3:0]               en_out,
  output logic                     sk_out
);

  if (TMR_BITS < 2) begin : g_chk
    $error("TMR_BITS must be at least 2");
  end

  logic [1:0]            phase_r;
  logic                  run_r;
  fmc_pkg::fmc_state_t   state_r, state_nxt;
  logic [9:0]            pc_r, pc_nxt, sa_r, sa_nxt, sb_r, sb_nxt, sc_r, sc_nxt;
  logic [3:0]            a_r, a_nxt, bd_r, bd_nxt, sio_r, sio_nxt;
  logic [1:0]            br_r, br_nxt;
  logic                  c_r, c_nxt, skl_r, skl_nxt;
  logic                  skip_r, skip_nxt, lbi_r, lbi_nxt;
  logic [7:0]            op1_r, op1_nxt, q_r, q_nxt;
  logic [3:0]            g_r, g_nxt, d_r, d_nxt, en_r, en_nxt;
  logic [3:0]            ram_r [0:63];
  logic                  ram_we;
  logic [5:0]            ram_wa;
  logic [3:0]            ram_wd;
  logic                  tmr_clr, il_clr;
  logic [TMR_BITS-1:0]   tmr_cnt_r;
  logic                  tmr_flag_r;
  logic                  il3_r, il0_r;
  logic [1:0]            hist3_r, hist0_r;
  fmc_pkg::fmc_pins_t    pin_s1_r, pin_s2_r;
  logic                  ic_tick, exec;
  logic [9:0]            pc_inc;
  logic [3:0]            m;
  logic [4:0]            sum;
  logic [7:0]            rb;
  logic                  wb_hit;

  // Sum of two digits and carry in, carry out in bit 4
  function automatic logic [4:0] add4(input logic [3:0] x, input logic [3:0] y,
                                      input logic ci);
    add4 = {1'b0, x} + {1'b0, y} + {4'h0, ci};
  endfunction

  // Digit with one bit forced
  function automatic logic [3:0] put_bit(input logic [3:0] v, input logic [1:0] i,
                                         input logic b);
    put_bit = v;
    put_bit[i] = b;
  endfunction

  assign ic_tick = run_r && (phase_r == `FMC_PHASE_LAST);
  assign exec    = ic_tick;
  assign pc_inc  = pc_r + 10'h001;
  assign m       = ram_r[{br_r, bd_r}];
  assign rb      = rom_data;
  assign wb_hit  = wb_req.cyc && wb_req.stb && !wb_ack_o;

  // Pins cross into mclk through two flops; only the second is read
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Wishbone slave: one wait state, ack drops the cycle after it is given
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      run_r    <= `FMC_CTRL_RST;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_hit && wb_req.we) begin
        if (wb_req.adr == `FMC_OFF_CTRL && wb_req.sel[0]) begin
          run_r <= wb_req.dat[`FMC_CTRL_RUN_BIT];
        end
      end else if (wb_hit) begin
        case (wb_req.adr)
          `FMC_OFF_CTRL: wb_dat_o <= {31'h0, run_r};
          `FMC_OFF_STAT: wb_dat_o <= {8'h0, state_r, bd_r, br_r, skip_r, c_r, a_r, pc_r};
          `FMC_OFF_PORT: wb_dat_o <= {8'h0, tmr_flag_r, il3_r, il0_r, skl_r, en_r, d_r,
                                      g_r, q_r};
          default:       wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Instruction cycle is four mclk; ROM address presented in the first phase
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r  <= `FMC_PHASE_FIRST;
      rom_addr <= `FMC_PC_RST;
    end else if (run_r) begin
      phase_r <= phase_r + 2'h1;
      if (phase_r == `FMC_PHASE_FIRST) begin
        rom_addr <= (state_r == fmc_pkg::FMC_ST_IND) ? {pc_r[9:8], a_r, m} : pc_r;
      end
    end
  end

  // Decode and execute; every cycle but the indirect one counts one byte, skipped or not
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    sa_nxt = sa_r;
    sb_nxt = sb_r;
    sc_nxt = sc_r;
    a_nxt = a_r;
    c_nxt = c_r;
    br_nxt = br_r;
    bd_nxt = bd_r;
    sio_nxt = sio_r;
    skl_nxt = skl_r;
    skip_nxt = skip_r;
    lbi_nxt = lbi_r;
    op1_nxt = op1_r;
    q_nxt = q_r;
    g_nxt = g_r;
    d_nxt = d_r;
    en_nxt = en_r;
    ram_we = 1'b0;
    ram_wa = {br_r, bd_r};
    ram_wd = m;
    tmr_clr = 1'b0;
    il_clr = 1'b0;
    sum = 5'h00;
    if (exec) begin
      case (state_r)
        fmc_pkg::FMC_ST_OP1: begin
          pc_nxt = pc_inc;
          if (rb == `FMC_OP_PREFIX_R || rb == `FMC_OP_PREFIX_IO || rb[7:4] == 4'h6) begin
            op1_nxt = rb;
            state_nxt = fmc_pkg::FMC_ST_OP2;
          end else if (skip_r) begin
            skip_nxt = 1'b0;
          end else if (lbi_r && rb[7:6] == 2'b00 && rb[3]) begin
            lbi_nxt = 1'b1;
          end else begin
            lbi_nxt = 1'b0;
            casez (rb)
              8'h00: a_nxt = 4'h0;
              8'h01, 8'h11, 8'h03, 8'h13: skip_nxt = !m[{rb[1], rb[4]}];
              8'h02: a_nxt = a_r ^ m;
              8'h10: begin
                sum = add4(~a_r, m, c_r);
                a_nxt = sum[3:0];
                c_nxt = sum[4];
                skip_nxt = sum[4];
              end
              8'h12: begin
                a_nxt = {2'b00, br_r};
                br_nxt = a_r[1:0];
              end
              8'h20: skip_nxt = c_r;
              8'h21: skip_nxt = (a_r == m);
              8'h22: c_nxt = 1'b1;
              8'h30: begin
                sum = add4(a_r, m, c_r);
                a_nxt = sum[3:0];
                c_nxt = sum[4];
                skip_nxt = sum[4];
              end
              8'h31: a_nxt = a_r + m;
              8'h32: c_nxt = 1'b0;
              8'b00??0100: begin
                ram_we = 1'b1;
                ram_wd = a_r;
                a_nxt = m;
                bd_nxt = bd_r + 4'h1;
                br_nxt = br_r ^ rb[5:4];
                skip_nxt = (bd_r == 4'hf);
              end
              8'b00??0101: begin
                a_nxt = m;
                br_nxt = br_r ^ rb[5:4];
              end
              8'b00??0110: begin
                ram_we = 1'b1;
                ram_wd = a_r;
                a_nxt = m;
                br_nxt = br_r ^ rb[5:4];
              end
              8'b00??0111: begin
                ram_we = 1'b1;
                ram_wd = a_r;
                a_nxt = m;
                bd_nxt = bd_r - 4'h1;
                br_nxt = br_r ^ rb[5:4];
                skip_nxt = (bd_r == 4'h0);
              end
              8'b00??1???: begin
                br_nxt = rb[5:4];
                bd_nxt = rb[3:0] + 4'h1;
                lbi_nxt = 1'b1;
              end
              8'h40: a_nxt = ~a_r;
              8'h41: begin
                skip_nxt = tmr_flag_r;
                tmr_clr = 1'b1;
              end
              8'h4c: begin ram_we = 1'b1; ram_wd = put_bit(m, 2'h0, 1'b0); end
              8'h45: begin ram_we = 1'b1; ram_wd = put_bit(m, 2'h1, 1'b0); end
              8'h42: begin ram_we = 1'b1; ram_wd = put_bit(m, 2'h2, 1'b0); end
              8'h43: begin ram_we = 1'b1; ram_wd = put_bit(m, 2'h3, 1'b0); end
              8'h4d: begin ram_we = 1'b1; ram_wd = put_bit(m, 2'h0, 1'b1); end
              8'h47: begin ram_we = 1'b1; ram_wd = put_bit(m, 2'h1, 1'b1); end
              8'h46: begin ram_we = 1'b1; ram_wd = put_bit(m, 2'h2, 1'b1); end
              8'h4b: begin ram_we = 1'b1; ram_wd = put_bit(m, 2'h3, 1'b1); end
              8'h48, 8'h49: begin
                pc_nxt = sa_r;
                sa_nxt = sb_r;
                sb_nxt = sc_r;
                skip_nxt = rb[0];
              end
              8'h4a: a_nxt = a_r + `FMC_ADT_TEN;
              8'h4e: a_nxt = bd_r;
              8'h4f: begin
                a_nxt = sio_r;
                sio_nxt = a_r;
                skl_nxt = c_r;
              end
              8'h50: bd_nxt = a_r;
              8'h5?: begin
                sum = add4(a_r, rb[3:0], 1'b0);
                a_nxt = sum[3:0];
                skip_nxt = sum[4];
              end
              8'h7?: begin
                ram_we = 1'b1;
                ram_wd = rb[3:0];
                bd_nxt = bd_r + 4'h1;
              end
              8'b1???????: begin
                if (rb == `FMC_OP_JID || rb == `FMC_OP_TABLE_LOOKUP_TO_Q) begin
                  op1_nxt = rb;
                  state_nxt = fmc_pkg::FMC_ST_IND;
                end else if (pc_inc[9:7] == `FMC_PAGE23) begin
                  pc_nxt = {pc_inc[9:7], rb[6:0]};
                end else if (rb[6]) begin
                  pc_nxt = {pc_inc[9:6], rb[5:0]};
                end else begin
                  sa_nxt = pc_inc;
                  sb_nxt = sa_r;
                  sc_nxt = sb_r;
                  pc_nxt = {`FMC_PAGE2_CALL_PAGE, rb[5:0]};
                end
              end
              default: a_nxt = a_r;
            endcase
          end
        end
        fmc_pkg::FMC_ST_OP2: begin
          pc_nxt = pc_inc;
          state_nxt = fmc_pkg::FMC_ST_OP1;
          if (skip_r) begin
            skip_nxt = 1'b0;
          end else if (lbi_r && op1_r == `FMC_OP_PREFIX_IO && rb[7:6] == 2'b10) begin
            lbi_nxt = 1'b1;
          end else if (op1_r == `FMC_OP_PREFIX_R) begin
            lbi_nxt = 1'b0;
            ram_wa = rb[5:0];
            a_nxt = ram_r[rb[5:0]];
            ram_we = rb[7];
            ram_wd = a_r;
          end else if (op1_r[7:4] == 4'h6) begin
            lbi_nxt = 1'b0;
            pc_nxt = {op1_r[1:0], rb};
            if (op1_r[3]) begin
              sa_nxt = pc_inc;
              sb_nxt = sa_r;
              sc_nxt = sb_r;
            end
          end else begin
            lbi_nxt = 1'b0;
            casez (rb)
              8'h01, 8'h11, 8'h03, 8'h13: skip_nxt = !pin_s2_r.g[{rb[1], rb[4]}];
              8'h21: skip_nxt = (pin_s2_r.g == 4'h0);
              8'h2a: a_nxt = pin_s2_r.g;
              8'h28: a_nxt = pin_s2_r.in;
              8'h29: begin
                a_nxt = {il3_r, CKO_IS_GP ? pin_s2_r.clock_pin_input : 1'b1, 1'b0, il0_r};
                il_clr = 1'b1;
              end
              8'h2e: begin
                ram_we = 1'b1;
                ram_wd = pin_s2_r.l[7:4];
                a_nxt = pin_s2_r.l[3:0];
              end
              8'h3e: d_nxt = bd_r;
              8'h3a: g_nxt = m;
              8'h3c: q_nxt = {a_r, m};
              8'h2c: begin
                ram_we = 1'b1;
                ram_wd = q_r[7:4];
                a_nxt = q_r[3:0];
              end
              8'h5?: g_nxt = rb[3:0];
              8'h6?: en_nxt = rb[3:0];
              8'b10??????: begin
                br_nxt = rb[5:4];
                bd_nxt = rb[3:0];
                lbi_nxt = 1'b1;
              end
              default: a_nxt = a_r;
            endcase
          end
        end
        fmc_pkg::FMC_ST_IND: begin
          state_nxt = fmc_pkg::FMC_ST_OP1;
          if (op1_r == `FMC_OP_JID) begin
            pc_nxt = {pc_r[9:8], rb};
          end else begin
            q_nxt = rb;
            sc_nxt = sb_r;
          end
        end
        default: state_nxt = fmc_pkg::FMC_ST_OP1;
      endcase
    end
  end

  // Sequencer, counter and stack
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= fmc_pkg::FMC_ST_OP1;
      pc_r    <= `FMC_PC_RST;
      sa_r    <= `FMC_PC_RST;
      sb_r    <= `FMC_PC_RST;
      sc_r    <= `FMC_PC_RST;
      op1_r   <= 8'h00;
      skip_r  <= 1'b0;
      lbi_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      sa_r    <= sa_nxt;
      sb_r    <= sb_nxt;
      sc_r    <= sc_nxt;
      op1_r   <= op1_nxt;
      skip_r  <= skip_nxt;
      lbi_r   <= lbi_nxt;
    end
  end

  // Working registers and output latches
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      a_r   <= 4'h0;
      c_r   <= 1'b0;
      br_r  <= 2'h0;
      bd_r  <= 4'h0;
      sio_r <= 4'h0;
      skl_r <= 1'b0;
      q_r   <= 8'h00;
      g_r   <= 4'h0;
      d_r   <= 4'h0;
      en_r  <= 4'h0;
    end else begin
      a_r   <= a_nxt;
      c_r   <= c_nxt;
      br_r  <= br_nxt;
      bd_r  <= bd_nxt;
      sio_r <= sio_nxt;
      skl_r <= skl_nxt;
      q_r   <= q_nxt;
      g_r   <= g_nxt;
      d_r   <= d_nxt;
      en_r  <= en_nxt;
    end
  end

  assign l_out  = q_r;
  assign g_out  = g_r;
  assign d_out  = d_r;
  assign en_out = en_r;
  assign sk_out = skl_r;

  // Data RAM, four rows of sixteen digits
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 64; i++) begin
        ram_r[i] <= `FMC_RAM_RST;
      end
    end else if (ram_we) begin
      ram_r[ram_wa] <= ram_wd;
    end
  end

  // Time base; a carry that meets a test in the same cycle is kept
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_cnt_r  <= '0;
      tmr_flag_r <= 1'b0;
    end else begin
      if (ic_tick) begin
        tmr_cnt_r <= tmr_cnt_r + {{(TMR_BITS-1){1'b0}}, 1'b1};
      end
      tmr_flag_r <= (ic_tick && (&tmr_cnt_r)) || (tmr_flag_r && !tmr_clr);
    end
  end

  // Pulse latches have no reset so a reset keeps their state
  // Sampled once per instruction cycle: high, then low twice, sets
  always_ff @(posedge mclk) begin
    if (ic_tick) begin
      hist3_r <= {hist3_r[0], pin_s2_r.in[3]};
      hist0_r <= {hist0_r[0], pin_s2_r.in[0]};
    end
    il3_r <= (ic_tick && hist3_r == 2'b10 && !pin_s2_r.in[3]) || (il3_r && !il_clr);
    il0_r <= (ic_tick && hist0_r == 2'b10 && !pin_s2_r.in[0]) || (il0_r && !il_clr);
  end

endmodule

`default_nettype wire

// [hdl/fmc_map.svh]
// Constants of the four-bit controller core: bus offsets, fields, reset values, counts.
// Assumes inclusion by bare name from the package and the core only.
//
// Overview of operation
// - Add with carry, carry out, skip on carry
// - Complement add with carry, skip on carry
// - Add immediate, carry untouched, skip on carry
// - Accumulator exclusive-or RAM digit, no skip
// - Indirect jump loads low counter, two cycles
// - Page-two call pushes, forces page two
// - In-page jump, seven bits in pages 2-3
// - Exit pops stack; exit-then-skip always skips
// - Load digit, toggle row by operand
// - Swap, step digit pointer, skip on rollover
// - Store immediate digit, increment digit pointer
// - Skip when selected RAM bit is zero
// - One-byte pointer load codes digit minus one
// - Skip consecutive pointer loads after one
// - Feature load copies operand to enables
// - Timer test skips on carry since test
// - Port G zero tests skip
// - Pulse latch sets on two-cycle low
// - Latch read packs latches, clock pin, zero
// - Reset leaves pulse latches untouched
// - Serial swap exchanges, carry to clock latch
// - Port L read splits to RAM, accumulator
// - Skipped bytes still take one cycle
// - Table lookup two cycles, second level copied
`ifndef FMC_MAP_SVH
`define FMC_MAP_SVH

`define FMC_ADR_W        4
`define FMC_OFF_CTRL     4'h0
`define FMC_OFF_STAT     4'h4
`define FMC_OFF_PORT     4'h8
`define FMC_CTRL_RUN_BIT 0
`define FMC_CTRL_RST     1'b0
`define FMC_PHASE_LAST   2'h3
`define FMC_PHASE_FIRST  2'h0
`define FMC_PC_RST       10'h000
`define FMC_RAM_RST      4'h0
`define FMC_PAGE23       3'h1
`define FMC_PAGE2_CALL_PAGE    4'h2
`define FMC_ADT_TEN      4'ha
`define FMC_TMR_BITS     10
`define FMC_OP_PREFIX_R  8'h23
`define FMC_OP_PREFIX_IO 8'h33
`define FMC_OP_JID       8'hff
`define FMC_OP_TABLE_LOOKUP_TO_Q      8'hbf

`endif

// [hdl/fmc_pkg.sv]
// Types shared by the four-bit controller core and its bench.
// Assumes fmc_map.svh is on the include path.
`include "fmc_map.svh"

package fmc_pkg;

  typedef enum logic [1:0] {
    FMC_ST_OP1 = 2'b00,
    FMC_ST_OP2 = 2'b01,
    FMC_ST_IND = 2'b10
  } fmc_state_t;

  typedef struct packed {
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [`FMC_ADR_W-1:0]  adr;
    logic [3:0]             sel;
    logic [31:0]            dat;
  } fmc_wb_req_t;

  typedef struct packed {
    logic [3:0] g;
    logic [3:0] in;
    logic [7:0] l;
    logic       clock_pin_input;
  } fmc_pins_t;

endpackage

// [verification/fmc_core_sva.sv]
// Checker for the four-bit controller core: bus handshake, fetch timing, port updates.
// Assumes it is bound to fmc_core and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none

module fmc_core_sva #(
  parameter int TMR_BITS  = 10,
  parameter bit CKO_IS_GP = 1'b0
) (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire fmc_pkg::fmc_wb_req_t  wb_req,
  input wire logic                  wb_ack_o,
  input wire logic [31:0]           wb_dat_o,
  input wire logic [9:0]            rom_addr,
  input wire logic [7:0]            rom_data,
  input wire fmc_pkg::fmc_pins_t    pins,
  input wire logic [7:0]            l_out,
  input wire logic [3:0]            g_out,
  input wire logic [3:0]            d_out,
  input wire logic [3:0]            en_out,
  input wire logic                  sk_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // A new fetch address appears at the start of an instruction cycle
  sequence s_fetch;
    $changed(rom_addr);
  endsequence

  // The indirect jump byte executes at the last phase of that fetch
  sequence s_exec_ind;
    s_fetch ##2 rom_data == 8'hff;
  endsequence

  // Bus handshake: one wait state, single-cycle ack, quiet data otherwise
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_wait: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one wait state");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");

  // Skipped or not, every byte owns a full four-phase fetch
  a_fetch_hold: assert property (s_fetch |=> $stable(rom_addr) [*3])
    else $error("fetch address moved inside an instruction cycle");

  // Enables only ever take the immediate of a feature load
  a_feature_copy: assert property ($changed(en_out) |-> $past(rom_data) == {4'h6, en_out})
    else $error("enable register changed without a feature load");

  // The serial clock latch only moves on a serial swap
  a_serial_clk: assert property ($changed(sk_out) |-> $past(rom_data) == 8'h4f)
    else $error("serial clock latch changed outside a serial swap");

  // The table read of an indirect jump stays in the current page group
  a_ind_page: assert property (s_exec_ind |-> ##2 rom_addr[9:8] == $past(rom_addr[9:8], 2))
    else $error("indirect jump left its page group");

  // Q takes the table byte, unless copied from the accumulator and RAM
  a_q_load: assert property ($changed(l_out) |->
                             l_out == $past(rom_data) || $past(rom_data) == 8'h3c)
    else $error("Q latch changed without a table read");
endmodule

bind fmc_core fmc_core_sva #(.TMR_BITS(TMR_BITS), .CKO_IS_GP(CKO_IS_GP)) u_sva (
  .mclk(mclk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .rom_addr(rom_addr), .rom_data(rom_data), .pins(pins),
  .l_out(l_out), .g_out(g_out), .d_out(d_out), .en_out(en_out), .sk_out(sk_out));

`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the four-bit controller core: runs short ROM programs.
// Assumes fmc_pkg is compiled first; the ROM is a bench array read combinationally.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic                  mclk = 1'b0;
  logic                  sys_rst;
  fmc_pkg::fmc_wb_req_t  wb_req;
  fmc_pkg::fmc_pins_t    pins;
  logic                  wb_ack_o;
  logic [31:0]           wb_dat_o;
  logic [9:0]            rom_addr;
  logic [7:0]            rom_data;
  logic [7:0]            l_out;
  logic [3:0]            g_out;
  logic [3:0]            d_out;
  logic [3:0]            en_out;
  logic                  sk_out;
  logic [7:0]            rom [0:1023];
  logic [31:0]           rd_q;
  int                    fail_count = 0;
  int                    checks = 0;
  int                    cyc_cnt = 0;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  // ROM settles at once, well inside the three-clock window
  assign rom_data = rom[rom_addr];

  // Short timer count keeps the overflow flag reachable in a short run
  fmc_core #(.TMR_BITS(3), .CKO_IS_GP(1'b0)) u_dut (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .wb_req   (wb_req),
    .wb_ack_o (wb_ack_o),
    .wb_dat_o (wb_dat_o),
    .rom_addr (rom_addr),
    .rom_data (rom_data),
    .pins     (pins),
    .l_out    (l_out),
    .g_out    (g_out),
    .d_out    (d_out),
    .en_out   (en_out),
    .sk_out   (sk_out)
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; holds everything until ack is sampled
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_req <= '0;
  endtask

  // Reset the core and load 32 program bytes at address 0, NOP elsewhere
  task automatic boot(input logic [255:0] code);
    sys_rst <= 1'b1;
    for (int i = 0; i < 1024; i++) begin
      rom[i] = (i < 32) ? code[255 - 8 * i -: 8] : 8'h44;
    end
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  // Let the core run n instruction cycles of four clocks each
  task automatic go(input int n);
    wb(1'b1, 4'h0, 32'h1);
    repeat (4 * n) @(posedge mclk);
    wb(1'b1, 4'h0, 32'h0);
  endtask

  // Expected status word: state, pointer, skip all zero
  function automatic logic [23:0] st(input logic [9:0] pc, input logic [3:0] a, input logic c);
    return {8'h00, 1'b0, c, a, pc};
  endfunction

  // Cut a hung run short; the tests need well under a thousand cycles
  always @(posedge mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // Main sequence: arithmetic, control flow, pointers and ports
  initial begin
    sys_rst = 1'b1;
    wb_req = '0;
    pins = '{g: 4'h0, in: 4'hf, l: 8'h6c, clock_pin_input: 1'b0};
    repeat (14) @(posedge mclk);
    // Adds with carry and skips, exclusive-or, complement add, loop at 0x00c
    boot(256'h0f7f0f22_53305202_5f32105f_cc444444_44444444_44444444_44444444_44444444);
    go(40);
    wb(1'b0, 4'h4, 32'h0);
    check(rd_q[23:0], st(10'h00c, 4'h4, 1'b1));
    wb(1'b0, 4'h8, 32'h0);
    check(rd_q[23], 1'b1);
    wb(1'b1, 4'hc, 32'hffffffff);
    wb(1'b0, 4'hc, 32'h0);
    check(rd_q, 32'h0);
    // Calls, returns, bit test, table read, indirect jump into page 2, then a jump on to page 3
    boot(256'h815f8253_0f750f01_115fbfff_44444444_44444444_44444444_44444444_44444444);
    rom[10'h081] = 8'h49;
    rom[10'h082] = 8'h48;
    rom[10'h035] = 8'ha0;
    rom[10'h0a0] = 8'he5;
    rom[10'h0e5] = 8'he5;
    pins.in <= 4'h6;
    go(40);
    wb(1'b0, 4'h4, 32'h0);
    check(rd_q[23:0], st(10'h0e5, 4'h3, 1'b0));
    check(l_out, 8'ha0);
    wb(1'b0, 4'h8, 32'h0);
    check(rd_q[22:21], 2'b11);
    // Pointer loads, swaps, port reads; latches must survive the reset
    boot(256'h0f08338f_7a338f79_338f145f_332e1522_4f332933_3c4f3365_d8444444_44444444);
    wb(1'b0, 4'h8, 32'h0);
    check(rd_q[22:21], 2'b11);
    go(40);
    wb(1'b0, 4'h4, 32'h0);
    check(rd_q[23:0], st(10'h018, 4'h6, 1'b1));
    check(l_out, 8'hda);
    wb(1'b0, 4'h8, 32'h0);
    check(rd_q[22:16], 7'h15);
    check({sk_out, en_out}, 5'h15);
    // Timer, port G and decrement-swap skips; G reads 1101, digit ends at 15
    boot(256'h41075851_33215233_11544158_cc444444_44444444_44444444_44444444_44444444);
    pins.g <= 4'hd;
    go(40);
    wb(1'b0, 4'h4, 32'h0);
    check(rd_q[23:0], st(10'h00c, 4'h3, 1'b0) | 24'h3c_0000);
    report_and_stop();
  end
endmodule

`default_nettype wire
